// ---- tmg_pkg.sv ----
`default_nettype none
package tmg_pkg;
  // Printed offset 0x29 is not word aligned: offsets are word indices
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_TX_VALUE = 8'h20;
  localparam logic [IDX_W-1:0] IDX_TY_VALUE = 8'h21;
  localparam logic [IDX_W-1:0] IDX_T1_VALUE = 8'h22;
  localparam logic [IDX_W-1:0] IDX_T2_VALUE = 8'h23;
  localparam logic [IDX_W-1:0] IDX_T3_VALUE = 8'h24;
  localparam logic [IDX_W-1:0] IDX_TX_MODE = 8'h25;
  localparam logic [IDX_W-1:0] IDX_TY_MODE = 8'h26;
  localparam logic [IDX_W-1:0] IDX_TY_CAPTURE = 8'h27;
  localparam logic [IDX_W-1:0] IDX_SPEED = 8'h28;
  localparam logic [IDX_W-1:0] IDX_T123_MODE = 8'h29;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h2B;

  // Timer 1/2/3 mode fields
  localparam int T123_TOUT_START = 0;
  localparam int T123_TOUT_EN = 1;
  localparam int T123_T2_LATCH_ONLY = 2;
  localparam int T123_T2_SRC = 3;
  localparam int T123_T3_SRC = 4;
  localparam int T123_T1_SRC = 5;
  localparam int T123_W = 6;
  localparam logic [T123_W-1:0] T123_RESET = 6'h00;

  // Timer X / Y mode fields
  localparam int MODE_LSB = 0;
  localparam int MODE_EDGE = 2;
  localparam int TX_LATCH_ONLY = 3;
  localparam int TX_STOP = 4;
  localparam int TX_MODE_W = 5;
  localparam int TY_STOP = 3;
  localparam int TY_MODE_W = 4;
  localparam logic [TX_MODE_W-1:0] TX_MODE_RESET = 5'h00;
  localparam logic [TY_MODE_W-1:0] TY_MODE_RESET = 4'h0;

  localparam int SPEED_LOW = 0;
  localparam logic [15:0] T16_RESET = 16'hFFFF;
  localparam logic [7:0] T8_RESET = 8'hFF;
  localparam int PRESCALE = 16;
  localparam int PRESCALE_W = $clog2(PRESCALE);
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(PRESCALE - 1);

  typedef enum logic [1:0] {XM_TIMER = 2'h0, XM_PULSE = 2'h1, XM_EVENT = 2'h2, XM_WIDTH = 2'h3} tmg_xmode_t;
  typedef enum logic [1:0] {YM_TIMER = 2'h0, YM_PERIOD = 2'h1, YM_EVENT = 2'h2, YM_HLCONT = 2'h3} tmg_ymode_t;
  typedef enum logic {BUS_IDLE = 1'b0, BUS_WRITE = 1'b1} tmg_bus_t;

  typedef struct packed {
    logic timerX;
    logic timerY;
    logic timer1;
    logic timer2;
    logic timer3;
    logic counterPinZero;
    logic counterPinOne;
  } tmg_req_t;

  function automatic logic selEdge(input logic rise, input logic fall, input logic useRise);
    return useRise ? rise : fall;
  endfunction
endpackage
`default_nettype wire

// ---- tmg_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmg_pin_sync
  import tmg_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic level_reg;
  logic level_next;
  logic agree;

  // Stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
  assign agree = sync_reg[1] == sync_reg[2];

  always_comb begin
    sync_next = {sync_reg[1:0], pin};
    level_next = agree ? sync_reg[2] : level_reg;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sync_reg <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
  assign rise = agree && sync_reg[2] && !level_reg;
  assign fall = agree && !sync_reg[2] && level_reg;
endmodule
`default_nettype wire

// ---- tmg_down_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmg_down_counter
  import tmg_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VALUE = '1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic tick,
  input wire logic wrLatch,
  input wire logic wrCounter,
  input wire logic [W-1:0] wrData,
  input wire logic reload,
  output logic [W-1:0] count,
  output logic underflow
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic [W-1:0] latch_reg;
  logic [W-1:0] latch_next;

  assign underflow = tick && (count_reg == '0);

  always_comb begin
    latch_next = wrLatch ? wrData : latch_reg;
    count_next = count_reg;
    if (wrCounter) begin
      count_next = wrData;
    end else if (reload || underflow) begin
      count_next = latch_reg;
    end else if (tick) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      count_reg <= RESET_VALUE;
      latch_reg <= RESET_VALUE;
    end else begin
      count_reg <= count_next;
      latch_reg <= latch_next;
    end
  end

  assign count = count_reg;
endmodule
`default_nettype wire

// ---- tmg_timer_group.sv ----
// Contract
// - Timer X timer mode: pin zero edge requests interrupt, 0 falling, 1 rising, no count.
// - Pulse output: edge 0 starts high, irq on falling; 1 starts low, irq rising.
// - Event mode X/Y: edge 0 counts rising, irq falling; 1 the reverse.
// - Width mode X: edge 0 measures high, irq falling; 1 measures low, irq rising.
// - Timer Y timer mode: pin one edge interrupt, 0 falling, 1 rising, no count.
// - Period mode Y: measure between selected edges, irq on that edge.
// - HL continuous Y: measure both widths, irq on every edge.
// - X latch-only write during underflow loads both timer and latch.
// - Mode bit 0 picks output start level: 0 high, 1 low.
// - Mode bit 1 gives the shared pin to the timer output.
// - Mode bit 2: Timer 2 write loads latch and counter, or latch only.
// - Bit 3: Timer 2 counts Timer 1 output, or oscillator divided by 16.
// - Bit 4: Timer 3 counts Timer 1 output, or oscillator divided by 16.
// - Bit 5: Timer 1 counts oscillator divided by 16, or undivided sub-clock.
// - Mode bits 6 and 7 read zero; software writes zero.
// - Low speed: system clock runs at half the sub-clock.
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module tmg_timer_group
  import tmg_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic subCrystalInput,
  input wire logic counterPinZeroIn,
  output logic counterPinZeroOut,
  output logic counterPinZeroOe_n,
  input wire logic counterPinOneIn,
  input wire logic toutPortData,
  input wire logic toutPortOe_n,
  output logic toutPinOut,
  output logic toutPinOe_n,
  output logic sysClkTick,
  output tmg_req_t req
);
  logic [1:0] rstPipe;
  logic rstN;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  logic c0Level, c0Rise, c0Fall, c1Level, c1Rise, c1Fall, subLevel, subRise, subFall;
  tmg_pin_sync u_sync_c0 (.clk(clk), .rstN(rstN), .pin(counterPinZeroIn),
    .level(c0Level), .rise(c0Rise), .fall(c0Fall));
  tmg_pin_sync u_sync_c1 (.clk(clk), .rstN(rstN), .pin(counterPinOneIn),
    .level(c1Level), .rise(c1Rise), .fall(c1Fall));
  tmg_pin_sync u_sync_sub (.clk(clk), .rstN(rstN), .pin(subCrystalInput),
    .level(subLevel), .rise(subRise), .fall(subFall));

  tmg_bus_t busState_reg, busState_next;
  logic [IDX_W-1:0] wrIdx_reg, wrIdx_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [TX_MODE_W-1:0] txMode_reg, txMode_next;
  logic [TY_MODE_W-1:0] tyMode_reg, tyMode_next;
  logic [T123_W-1:0] timer_one_two_three_mode_reg, timer_one_two_three_mode_next;
  logic lowSpeed_reg, lowSpeed_next;
  logic [15:0] capture_reg, capture_next;
  logic [31:0] rdMux;
  logic addrValid, busWr;
  logic [IDX_W-1:0] addrIdx;

  assign addrValid = hsel && htrans[1] && hready;
  assign addrIdx = haddr[IDX_LSB +: IDX_W];
  assign busWr = busState_reg == BUS_WRITE;

  logic [15:0] xCount, yCount;
  logic [7:0] t1Count, t2Count, t3Count;
  logic xUf, yUf, t1Uf, t2Uf, t3Uf;
  logic pulseLevel_reg, pulseLevel_next, toutLevel_reg, toutLevel_next;

  always_comb begin
    case (addrIdx)
      IDX_TX_VALUE: rdMux = {16'h0000, xCount};
      IDX_TY_VALUE: rdMux = {16'h0000, yCount};
      IDX_T1_VALUE: rdMux = {24'h000000, t1Count};
      IDX_T2_VALUE: rdMux = {24'h000000, t2Count};
      IDX_T3_VALUE: rdMux = {24'h000000, t3Count};
      IDX_TX_MODE: rdMux = {27'h0000000, txMode_reg};
      IDX_TY_MODE: rdMux = {28'h0000000, tyMode_reg};
      IDX_TY_CAPTURE: rdMux = {16'h0000, capture_reg};
      IDX_SPEED: rdMux = {31'h00000000, lowSpeed_reg};
      IDX_T123_MODE: rdMux = {26'h0000000, timer_one_two_three_mode_reg};
      IDX_STATUS: rdMux = {28'h0000000, c1Level, c0Level, toutLevel_reg, pulseLevel_reg};
      default: rdMux = 32'h00000000;
    endcase
  end

  // Read data is caught at the address phase so the slave never waits
  always_comb begin
    busState_next = (addrValid && hwrite) ? BUS_WRITE : BUS_IDLE;
    wrIdx_next = addrValid ? addrIdx : wrIdx_reg;
    hrdata_next = (addrValid && !hwrite) ? rdMux : hrdata_reg;
    txMode_next = txMode_reg;
    tyMode_next = tyMode_reg;
    timer_one_two_three_mode_next = timer_one_two_three_mode_reg;
    lowSpeed_next = lowSpeed_reg;
    if (busWr) begin
      case (wrIdx_reg)
        IDX_TX_MODE: txMode_next = hwdata[TX_MODE_W-1:0];
        IDX_TY_MODE: tyMode_next = hwdata[TY_MODE_W-1:0];
        IDX_SPEED: lowSpeed_next = hwdata[SPEED_LOW];
        IDX_T123_MODE: timer_one_two_three_mode_next = hwdata[T123_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busState_reg <= BUS_IDLE;
      wrIdx_reg <= '0;
      hrdata_reg <= 32'h00000000;
      txMode_reg <= TX_MODE_RESET;
      tyMode_reg <= TY_MODE_RESET;
      timer_one_two_three_mode_reg <= T123_RESET;
      lowSpeed_reg <= 1'b0;
    end else begin
      busState_reg <= busState_next;
      wrIdx_reg <= wrIdx_next;
      hrdata_reg <= hrdata_next;
      txMode_reg <= txMode_next;
      tyMode_reg <= tyMode_next;
      timer_one_two_three_mode_reg <= timer_one_two_three_mode_next;
      lowSpeed_reg <= lowSpeed_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  logic wrTx, wrTy, wrT1, wrT2, wrT3;
  assign wrTx = busWr && wrIdx_reg == IDX_TX_VALUE;
  assign wrTy = busWr && wrIdx_reg == IDX_TY_VALUE;
  assign wrT1 = busWr && wrIdx_reg == IDX_T1_VALUE;
  assign wrT2 = busWr && wrIdx_reg == IDX_T2_VALUE;
  assign wrT3 = busWr && wrIdx_reg == IDX_T3_VALUE;

  // Prescaler on main clock, or on sub-clock edges in low speed
  logic [PRESCALE_W-1:0] prescale_reg, prescale_next;
  logic sysDiv_reg, sysDiv_next, sysTick_reg, sysTick_next;
  logic srcTick, div16;
  tmg_req_t req_reg, req_next;
  assign srcTick = lowSpeed_reg ? subRise : 1'b1;
  assign div16 = srcTick && prescale_reg == PRESCALE_LAST;

  tmg_xmode_t xMode;
  tmg_ymode_t yMode;
  logic xEdge, yEdge, xTick, yTick, yReload, xLatchOnly, t2LatchOnly;
  assign xMode = tmg_xmode_t'(txMode_reg[MODE_LSB +: 2]);
  assign yMode = tmg_ymode_t'(tyMode_reg[MODE_LSB +: 2]);
  assign xEdge = txMode_reg[MODE_EDGE];
  assign yEdge = tyMode_reg[MODE_EDGE];
  assign xLatchOnly = txMode_reg[TX_LATCH_ONLY];
  assign t2LatchOnly = timer_one_two_three_mode_reg[T123_T2_LATCH_ONLY];

  always_comb begin
    case (xMode)
      XM_EVENT: xTick = selEdge(c0Rise, c0Fall, !xEdge);
      XM_WIDTH: xTick = div16 && (c0Level == !xEdge);
      default: xTick = div16;
    endcase
    xTick = xTick && !txMode_reg[TX_STOP];
    case (yMode)
      YM_EVENT: yTick = selEdge(c1Rise, c1Fall, !yEdge);
      default: yTick = div16;
    endcase
    yTick = yTick && !tyMode_reg[TY_STOP];
    case (yMode)
      YM_PERIOD: yReload = selEdge(c1Rise, c1Fall, yEdge);
      YM_HLCONT: yReload = c1Rise || c1Fall;
      default: yReload = 1'b0;
    endcase
  end

  tmg_down_counter #(.W(16), .RESET_VALUE(T16_RESET)) u_tx (.clk(clk), .rstN(rstN), .tick(xTick),
    .wrLatch(wrTx), .wrCounter(wrTx && (!xLatchOnly || xUf)),
    .wrData(hwdata[15:0]), .reload(1'b0), .count(xCount), .underflow(xUf));
  tmg_down_counter #(.W(16), .RESET_VALUE(T16_RESET)) u_ty (.clk(clk), .rstN(rstN), .tick(yTick),
    .wrLatch(wrTy), .wrCounter(wrTy), .wrData(hwdata[15:0]), .reload(yReload),
    .count(yCount), .underflow(yUf));
  tmg_down_counter #(.W(8), .RESET_VALUE(T8_RESET)) u_t1 (.clk(clk), .rstN(rstN),
    .tick(timer_one_two_three_mode_reg[T123_T1_SRC] ? subRise : div16),
    .wrLatch(wrT1), .wrCounter(wrT1), .wrData(hwdata[7:0]), .reload(1'b0),
    .count(t1Count), .underflow(t1Uf));
  tmg_down_counter #(.W(8), .RESET_VALUE(T8_RESET)) u_t2 (.clk(clk), .rstN(rstN),
    .tick(timer_one_two_three_mode_reg[T123_T2_SRC] ? div16 : t1Uf),
    .wrLatch(wrT2), .wrCounter(wrT2 && !t2LatchOnly),
    .wrData(hwdata[7:0]), .reload(1'b0), .count(t2Count), .underflow(t2Uf));
  tmg_down_counter #(.W(8), .RESET_VALUE(T8_RESET)) u_t3 (.clk(clk), .rstN(rstN),
    .tick(timer_one_two_three_mode_reg[T123_T3_SRC] ? div16 : t1Uf),
    .wrLatch(wrT3), .wrCounter(wrT3), .wrData(hwdata[7:0]), .reload(1'b0),
    .count(t3Count), .underflow(t3Uf));

  always_comb begin
    prescale_next = srcTick ? prescale_reg + 1'b1 : prescale_reg;
    sysDiv_next = lowSpeed_reg ? (sysDiv_reg ^ subRise) : 1'b0;
    sysTick_next = lowSpeed_reg ? (subRise && sysDiv_reg) : 1'b1;
    capture_next = yReload ? yCount : capture_reg;
    // Pulse pin idles at its start level until pulse mode toggles it
    if (xMode == XM_PULSE) begin
      pulseLevel_next = pulseLevel_reg ^ xUf;
    end else begin
      pulseLevel_next = !xEdge;
    end
    if (timer_one_two_three_mode_reg[T123_TOUT_EN]) begin
      toutLevel_next = toutLevel_reg ^ t2Uf;
    end else begin
      // Preset from the incoming value so enable and start level may share one write
      toutLevel_next = !timer_one_two_three_mode_next[T123_TOUT_START];
    end
    req_next.timerX = xUf;
    req_next.timerY = yUf;
    req_next.timer1 = t1Uf;
    req_next.timer2 = t2Uf;
    req_next.timer3 = t3Uf;
    if (xMode == XM_PULSE) begin
      req_next.counterPinZero = xUf && (pulseLevel_reg != xEdge);
    end else begin
      req_next.counterPinZero = selEdge(c0Rise, c0Fall, xEdge);
    end
    if (yMode == YM_HLCONT) begin
      req_next.counterPinOne = c1Rise || c1Fall;
    end else begin
      req_next.counterPinOne = selEdge(c1Rise, c1Fall, yEdge);
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prescale_reg <= '0;
      sysDiv_reg <= 1'b0;
      sysTick_reg <= 1'b0;
      capture_reg <= 16'h0000;
      pulseLevel_reg <= 1'b1;
      toutLevel_reg <= 1'b1;
      req_reg <= '0;
    end else begin
      prescale_reg <= prescale_next;
      sysDiv_reg <= sysDiv_next;
      sysTick_reg <= sysTick_next;
      capture_reg <= capture_next;
      pulseLevel_reg <= pulseLevel_next;
      toutLevel_reg <= toutLevel_next;
      req_reg <= req_next;
    end
  end

  assign counterPinZeroOut = pulseLevel_reg;
  assign counterPinZeroOe_n = xMode != XM_PULSE;
  assign toutPinOut = timer_one_two_three_mode_reg[T123_TOUT_EN] ? toutLevel_reg : toutPortData;
  assign toutPinOe_n = timer_one_two_three_mode_reg[T123_TOUT_EN] ? 1'b0 : toutPortOe_n;
  assign sysClkTick = sysTick_reg;
  assign req = req_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstN);

  property p_tout_start;
    !timer_one_two_three_mode_reg[T123_TOUT_EN] |=> toutLevel_reg == !timer_one_two_three_mode_reg[T123_TOUT_START];
  endproperty
  a_tout_start: assert property (p_tout_start) else $error("tout start level wrong");
  property p_tout_pin;
    timer_one_two_three_mode_reg[T123_TOUT_EN] |-> toutPinOut == toutLevel_reg && !toutPinOe_n;
  endproperty
  a_tout_pin: assert property (p_tout_pin) else $error("tout pin not driven by timer");
  property p_t2_latch_only;
    wrT2 && t2LatchOnly && !u_t2.tick |=> $stable(t2Count);
  endproperty
  a_t2_latch_only: assert property (p_t2_latch_only) else $error("latch-only write moved timer 2");
  property p_mode_read_zero;
    addrValid && !hwrite && addrIdx == IDX_T123_MODE |=> hrdata[31:T123_W] == '0 && hrdata[T123_W-1:0] == $past(timer_one_two_three_mode_reg);
  endproperty
  a_mode_read_zero: assert property (p_mode_read_zero) else $error("mode register read wrong");
  property p_x_coincide;
    wrTx && xLatchOnly && xUf |=> xCount == $past(hwdata[15:0]);
  endproperty
  a_x_coincide: assert property (p_x_coincide) else $error("coinciding write not loaded to timer X");
  property p_x_timer_irq;
    xMode == XM_TIMER && !xEdge && c0Fall |=> req.counterPinZero ##1 !req.counterPinZero;
  endproperty
  a_x_timer_irq: assert property (p_x_timer_irq) else $error("pin zero falling request missing");
  property p_y_hl_irq;
    yMode == YM_HLCONT && (c1Rise || c1Fall) |=> req.counterPinOne && capture_reg == $past(yCount);
  endproperty
  a_y_hl_irq: assert property (p_y_hl_irq) else $error("HL edge not captured");
  property p_t1_hold;
    !timer_one_two_three_mode_reg[T123_T1_SRC] && !div16 && !wrT1 |=> t1Count == $past(t1Count);
  endproperty
  a_t1_hold: assert property (p_t1_hold) else $error("timer 1 counted without its source");
  property p_low_speed_sys;
    lowSpeed_reg && $past(lowSpeed_reg) && sysClkTick |-> !$past(sysTick_reg) && $past(subRise);
  endproperty
  a_low_speed_sys: assert property (p_low_speed_sys) else $error("system tick not half sub-clock");
  property p_pulse_toggle;
    xMode == XM_PULSE && $past(xMode) == XM_PULSE && xUf |=> pulseLevel_reg != $past(pulseLevel_reg);
  endproperty
  a_pulse_toggle: assert property (p_pulse_toggle) else $error("pulse output did not toggle");

  c_t2_underflow: cover property (t2Uf && timer_one_two_three_mode_reg[T123_TOUT_EN]);
  c_x_pulse_irq: cover property (xMode == XM_PULSE && req.counterPinZero);
  c_y_period: cover property (yMode == YM_PERIOD && yReload);
  c_coincide: cover property (wrTx && xLatchOnly && xUf);
endmodule
`default_nettype wire

// ---- tmg_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmg_pin_model (
  input wire logic counterPinZeroOut,
  input wire logic counterPinZeroOe_n,
  output logic counterPinZeroIn,
  output logic counterPinOneIn,
  output logic subCrystalInput
);
  logic zeroDrive = 1'b0;
  logic oneDrive = 1'b0;
  logic subLevel = 1'b0;
  // Device drive wins while its enable is low
  assign counterPinZeroIn = counterPinZeroOe_n ? zeroDrive : counterPinZeroOut;
  assign counterPinOneIn = oneDrive;
  assign subCrystalInput = subLevel;

  task automatic setZero(input logic v);
    zeroDrive <= v;
  endtask

  task automatic setOne(input logic v);
    oneDrive <= v;
  endtask

  // Half period unrelated to the system clock; idle low between bursts
  task automatic subRun(input int n);
    repeat (n) begin
      #41 subLevel <= 1'b1;
      #41 subLevel <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tmg_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic toutPortData = 1'b1;
  logic toutPortOe_n = 1'b1;
  wire logic hreadyout, hresp, toutPinOut, toutPinOe_n, sysClkTick;
  wire logic counterPinZeroOut, counterPinZeroOe_n, counterPinZeroIn, counterPinOneIn, subCrystalInput;
  wire logic [31:0] hrdata;
  tmg_req_t req;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  int cnt [9];
  logic toutLast = 1'b0;
  // Bits: timer Y, mode, edge, request on rise, request on fall
  localparam logic [5:0] PIN_TBL [13] = '{6'h01, 6'h06, 6'h11, 6'h16, 6'h19, 6'h1E,
    6'h21, 6'h26, 6'h29, 6'h2E, 6'h31, 6'h36, 6'h3B};

  always #2.5 clk = ~clk;

  tmg_timer_group i_tmg_timer_group (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .subCrystalInput(subCrystalInput),
    .counterPinZeroIn(counterPinZeroIn), .counterPinZeroOut(counterPinZeroOut),
    .counterPinZeroOe_n(counterPinZeroOe_n), .counterPinOneIn(counterPinOneIn),
    .toutPortData(toutPortData), .toutPortOe_n(toutPortOe_n), .toutPinOut(toutPinOut),
    .toutPinOe_n(toutPinOe_n), .sysClkTick(sysClkTick), .req(req));

  tmg_pin_model i_tmg_pin_model (.counterPinZeroOut(counterPinZeroOut),
    .counterPinZeroOe_n(counterPinZeroOe_n), .counterPinZeroIn(counterPinZeroIn),
    .counterPinOneIn(counterPinOneIn), .subCrystalInput(subCrystalInput));

  always @(posedge clk) begin
    cycles++;
    if (req.counterPinZero === 1'b1) cnt[0]++;
    if (req.counterPinOne === 1'b1) cnt[1]++;
    if (req.timer1 === 1'b1) cnt[2]++;
    if (req.timer2 === 1'b1) cnt[3]++;
    if (req.timer3 === 1'b1) cnt[4]++;
    if (sysClkTick === 1'b1) cnt[5]++;
    if (req.timerX === 1'b1) cnt[7]++;
    if (req.timerY === 1'b1) cnt[8]++;
    if (toutPinOut !== toutLast) cnt[6]++;
    toutLast = toutPinOut;
    if (cycles == 20000) begin
      err_total++;
      $display("CHECK FAILED run length expected below 20000 seen %0d", cycles);
      close_out();
    end
  end

  task automatic clr();
    foreach (cnt[i]) cnt[i] = 0;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic rngChk(input string name, input int seen, input int lo, input int hi);
    check(name, (seen >= lo && seen <= hi) ? 32'h1 : 32'h0, 32'h1);
  endtask

  task automatic busXfer(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
                         output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Two settle cycles so registered outputs are looked at after they land
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    busXfer(1'b1, idx, wd, d);
    repeat (2) @(negedge clk);
  endtask

  task automatic rdChk(input string name, input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    busXfer(1'b0, idx, 32'h0, d);
    check(name, d, exp);
  endtask

  task automatic test_reset();
    rdChk("mode reset", IDX_T123_MODE, 32'h0);
    check("okay response", 32'(hresp), 32'h0);
    rdChk("unmapped read", 8'h2A, 32'h0);
    wr(IDX_T123_MODE, 32'hFF);
    rdChk("mode upper bits", IDX_T123_MODE, 32'h3F);
    check("tout enabled oe", 32'(toutPinOe_n), 32'h0);
    check("tout start low", 32'(toutPinOut), 32'h0);
    wr(IDX_T123_MODE, 32'h00);
    wr(IDX_T123_MODE, 32'h02);
    check("tout start high", 32'(toutPinOut), 32'h1);
    toutPortData <= 1'b0;
    toutPortOe_n <= 1'b0;
    wr(IDX_T123_MODE, 32'h00);
    check("tout port data", 32'(toutPinOut), 32'h0);
    check("tout port oe", 32'(toutPinOe_n), 32'h0);
    $display("test reset and mode register done");
  endtask

  task automatic test_pulse();
    wr(IDX_TX_MODE, 32'h01);
    check("pulse oe", 32'(counterPinZeroOe_n), 32'h0);
    check("pulse start high", 32'(counterPinZeroOut), 32'h1);
    wr(IDX_TX_MODE, 32'h04);
    wr(IDX_TX_MODE, 32'h05);
    check("pulse start low", 32'(counterPinZeroOut), 32'h0);
    wr(IDX_TX_MODE, 32'h00);
    $display("test pulse output done");
  endtask

  task automatic setPin(input logic y, input logic v);
    if (y) i_tmg_pin_model.setOne(v);
    else i_tmg_pin_model.setZero(v);
    repeat (10) @(posedge clk);
  endtask

  task automatic test_pins();
    logic [5:0] e;
    for (int i = 0; i < 13; i++) begin
      e = PIN_TBL[i];
      wr(e[5] ? IDX_TY_MODE : IDX_TX_MODE, {29'h0, e[2], e[4:3]});
      clr();
      setPin(e[5], 1'b1);
      check("pin request on rise", 32'(cnt[e[5]]), 32'(e[1]));
      setPin(e[5], 1'b0);
      check("pin requests total", 32'(cnt[e[5]]), 32'(e[1]) + 32'(e[0]));
    end
    wr(IDX_TX_MODE, 32'h02);
    wr(IDX_TX_VALUE, 32'h10);
    repeat (3) begin
      setPin(1'b0, 1'b1);
      setPin(1'b0, 1'b0);
    end
    rdChk("event count", IDX_TX_VALUE, 32'h0D);
    wr(IDX_TY_MODE, 32'h02);
    wr(IDX_TX_VALUE, 32'h1);
    wr(IDX_TY_VALUE, 32'h1);
    clr();
    repeat (3) begin
      setPin(1'b0, 1'b1);
      setPin(1'b1, 1'b1);
      setPin(1'b0, 1'b0);
      setPin(1'b1, 1'b0);
    end
    check("timer X underflow", 32'(cnt[7]), 32'h1);
    check("timer Y underflow", 32'(cnt[8]), 32'h1);
    rdChk("timer X after reload", IDX_TX_VALUE, 32'h0);
    wr(IDX_TX_MODE, 32'h1A);
    wr(IDX_TX_VALUE, 32'h5);
    setPin(1'b0, 1'b1);
    setPin(1'b0, 1'b0);
    rdChk("timer X stopped latch only", IDX_TX_VALUE, 32'h0);
    wr(IDX_TX_MODE, 32'h0A);
    setPin(1'b0, 1'b1);
    setPin(1'b0, 1'b0);
    rdChk("timer X reload from latch", IDX_TX_VALUE, 32'h5);
    $display("test pin edges done");
  endtask

  // Sources first, then timers 1, 2, 3 in order
  task automatic chain(input logic [31:0] mode, input int e2, input int e3);
    wr(IDX_T123_MODE, mode);
    wr(IDX_T1_VALUE, 32'h1);
    wr(IDX_T2_VALUE, 32'h1);
    wr(IDX_T3_VALUE, 32'h1);
    clr();
    repeat (640) @(posedge clk);
    rngChk("timer1 underflows", cnt[2], 19, 21);
    rngChk("timer2 underflows", cnt[3], e2 - 1, e2 + 1);
    rngChk("timer3 underflows", cnt[4], e3 - 1, e3 + 1);
    rngChk("tout toggles", cnt[6], e2 - 1, e2 + 1);
    $display("test timer chain done");
  endtask

  task automatic test_latch();
    logic [31:0] d;
    // Timer 1 on the idle sub-clock keeps timer 2 still
    wr(IDX_T123_MODE, 32'h24);
    wr(IDX_T1_VALUE, 32'h1);
    busXfer(1'b0, IDX_T2_VALUE, 32'h0, d);
    wr(IDX_T2_VALUE, 32'h55);
    rdChk("timer2 latch only", IDX_T2_VALUE, d);
    wr(IDX_T123_MODE, 32'h20);
    wr(IDX_T2_VALUE, 32'h66);
    rdChk("timer2 direct", IDX_T2_VALUE, 32'h66);
    clr();
    i_tmg_pin_model.subRun(8);
    repeat (10) @(posedge clk);
    rngChk("timer1 on sub-clock", cnt[2], 4, 4);
    $display("test latch and sub source done");
  endtask

  task automatic test_speed();
    wr(IDX_SPEED, 32'h1);
    clr();
    i_tmg_pin_model.subRun(8);
    repeat (10) @(posedge clk);
    rngChk("low speed ticks", cnt[5], 4, 4);
    wr(IDX_SPEED, 32'h0);
    check("full speed tick", 32'(sysClkTick), 32'h1);
    $display("test speed done");
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    test_reset();
    test_pulse();
    test_pins();
    chain(32'h12, 10, 20);
    chain(32'h0A, 20, 10);
    test_latch();
    test_speed();
    close_out();
  end
endmodule
`default_nettype wire
